// >>> rtl/eas_pkg.sv
// Shared constants and helpers for the event/action sequencer.
// Assumes a single clock domain and that every user of it writes eas_pkg::name.
package eas_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sequence sizing
    localparam int unsigned PAIRS_MAX = 20;
    localparam int unsigned IDX_W     = 5;
    localparam logic [IDX_W-1:0] IDX_ZERO  = 5'h00;
    localparam logic [IDX_W-1:0] IDX_ONE   = 5'h01;
    localparam logic [IDX_W-1:0] PAIRS_TOP = 5'h14;
    localparam int unsigned ACT_W     = 5;
    localparam logic [ACT_W-1:0] ACT_NONE  = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // Boolean sources
    localparam int unsigned STATUS_W  = 16;
    localparam int unsigned DIN_W     = 8;
    localparam int unsigned TIMER_N   = 4;
    localparam int unsigned CMP_N     = 4;
    localparam int unsigned RULE_N    = 4;
    localparam int unsigned RULE_IN_N = 3;

    // Operand vector layout, one select code per bit
    localparam int unsigned OP_FALSE       = 0;
    localparam int unsigned OP_TRUE        = 1;
    localparam int unsigned OP_STATUS_BASE = 2;
    localparam int unsigned OP_DIN_BASE    = 18;
    localparam int unsigned OP_TIMER_BASE  = 26;
    localparam int unsigned OP_CMP_BASE    = 30;
    localparam int unsigned OP_RULE_BASE   = 34;
    localparam int unsigned OPERAND_W      = 38;
    localparam int unsigned SEL_W          = 6;

    // In the rule view the rule slots carry sequence events instead
    localparam int unsigned EV_FIRED_SLOT   = 0;
    localparam int unsigned EV_RUNNING_SLOT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Comparators
    localparam int unsigned VAR_N     = 4;
    localparam int unsigned VAR_W     = 16;
    localparam int unsigned VSEL_W    = 2;
    localparam logic [1:0]  CMP_LESS  = 2'h0;
    localparam logic [1:0]  CMP_EQUAL = 2'h1;
    localparam logic [1:0]  CMP_MORE  = 2'h2;
    localparam logic [1:0]  CMP_DIFF  = 2'h3;

    // Logic rule operators
    localparam logic OPR_AND = 1'b0;
    localparam logic OPR_OR  = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Out-of-range codes read as false
    function automatic logic pick_bit(
        input logic [OPERAND_W-1:0] vec,
        input logic [SEL_W-1:0]     sel
    );
        logic r;
        r = 1'b0;
        if (int'(sel) < OPERAND_W)
        begin
            r = vec[sel];
        end
        return r;
    endfunction : pick_bit

endpackage : eas_pkg

// >>> rtl/eas_logic_rule.sv
// One boolean logic rule: up to three selected operands joined left to right.
// Assumes the operand vector is stable within the cycle; purely combinational.
`timescale 1ns/1ps
module eas_logic_rule (
    input  wire logic [eas_pkg::OPERAND_W-1:0]              operand_vec_in,
    input  wire logic [eas_pkg::RULE_IN_N*eas_pkg::SEL_W-1:0] select_in,
    input  wire logic [eas_pkg::RULE_IN_N-1:0]              invert_in,
    input  wire logic [eas_pkg::RULE_IN_N-1:0]              enable_in,
    input  wire logic [eas_pkg::RULE_IN_N-2:0]              operator_in,
    output logic                                            result_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [eas_pkg::RULE_IN_N-1:0] term;
    logic                          acc;
    logic                          have;

    // Disabled operands drop out, so one or two inputs also work
    always_comb
    begin
        acc  = 1'b0;
        have = 1'b0;
        for (int i = 0; i < eas_pkg::RULE_IN_N; i++)
        begin
            term[i] = eas_pkg::pick_bit(operand_vec_in,
                          select_in[i*eas_pkg::SEL_W +: eas_pkg::SEL_W])
                      ^ invert_in[i];
            if (enable_in[i])
            begin
                if (!have)
                begin
                    acc = term[i];
                end
                else if (operator_in[(i > 0) ? i - 1 : 0] == eas_pkg::OPR_OR)
                begin
                    acc = acc | term[i];
                end
                else
                begin
                    acc = acc & term[i];
                end
                have = 1'b1;
            end
        end
        result_out = acc;
    end

endmodule : eas_logic_rule

// >>> rtl/eas_sequencer.sv
// Event/action sequencer with comparators and logic rules.
// Assumes all inputs synchronous to clk_in and a one-cycle scan strobe.
`timescale 1ns/1ps
module eas_sequencer (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   scan_strobe_in,
    input  wire logic                   start_in,
    input  wire logic                   stop_in,
    input  wire logic [4:0]             num_pairs_in,
    input  wire logic [119:0]           sequencer_event_select_in,
    input  wire logic [99:0]            sequencer_action_select_in,
    input  wire logic [15:0]            status_in,
    input  wire logic [7:0]             digital_in,
    input  wire logic [3:0]             timer_in,
    input  wire logic [63:0]            variable_in,
    input  wire logic [7:0]             cmp_var_select_in,
    input  wire logic [7:0]             cmp_op_in,
    input  wire logic [63:0]            cmp_preset_in,
    input  wire logic [71:0]            rule_operand_select_in,
    input  wire logic [11:0]            rule_operand_invert_in,
    input  wire logic [11:0]            rule_operand_enable_in,
    input  wire logic [7:0]             rule_operator_in,
    output logic                        running_out,
    output logic [4:0]                  seq_index_out,
    output logic                        action_valid_out,
    output logic [4:0]                  action_code_out,
    output logic [4:0]                  action_index_out,
    output logic                        event_true_out,
    output logic [3:0]                  comparator_out,
    output logic [3:0]                  rule_out
);

    ////////////////////////////////////////////////////////////////////////
    // Types and state
    typedef enum logic [1:0] {
        EAS_IDLE = 2'b01,
        EAS_RUN  = 2'b10
    } eas_state_type;

    eas_state_type                   state_reg;
    eas_state_type                   state_next;
    logic [eas_pkg::IDX_W-1:0]       seq_index_reg;
    logic [eas_pkg::IDX_W-1:0]       seq_index_next;
    logic                            action_valid_reg;
    logic [eas_pkg::ACT_W-1:0]       action_code_reg;
    logic [eas_pkg::IDX_W-1:0]       action_index_reg;
    logic                            event_true_reg;
    logic [eas_pkg::CMP_N-1:0]       comparator_reg;
    logic [eas_pkg::RULE_N-1:0]      rule_reg;

    logic [eas_pkg::CMP_N-1:0]       cmp_result;
    logic [eas_pkg::RULE_N-1:0]      rule_result;
    logic [eas_pkg::OPERAND_W-1:0]   event_vec;
    logic [eas_pkg::OPERAND_W-1:0]   rule_vec;
    logic [eas_pkg::IDX_W-1:0]       last_index;
    logic [eas_pkg::SEL_W-1:0]       cur_event_sel;
    logic                            cur_event_true;
    logic                            scan_eval;
    logic                            fire;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [eas_pkg::IDX_W-1:0] clamp_pairs(
        input logic [eas_pkg::IDX_W-1:0] n
    );
        logic [eas_pkg::IDX_W-1:0] r;
        r = n;
        if (n == eas_pkg::IDX_ZERO)
        begin
            r = eas_pkg::IDX_ONE;
        end
        else if (n > eas_pkg::PAIRS_TOP)
        begin
            r = eas_pkg::PAIRS_TOP;
        end
        return r;
    endfunction : clamp_pairs

    function automatic logic compare(
        input logic [eas_pkg::VAR_W-1:0] value,
        input logic [eas_pkg::VAR_W-1:0] preset,
        input logic [1:0]                op
    );
        logic r;
        case (op)
            eas_pkg::CMP_LESS:  r = value < preset;
            eas_pkg::CMP_EQUAL: r = value == preset;
            eas_pkg::CMP_MORE:  r = value > preset;
            eas_pkg::CMP_DIFF:  r = value != preset;
            default:            r = 1'b0;
        endcase
        return r;
    endfunction : compare

    ////////////////////////////////////////////////////////////////////////
    // Comparators, unsigned so a preset of zero never matches "less"
    always_comb
    begin
        for (int c = 0; c < eas_pkg::CMP_N; c++)
        begin
            cmp_result[c] = compare(
                variable_in[int'(cmp_var_select_in[c*eas_pkg::VSEL_W +:
                    eas_pkg::VSEL_W]) * eas_pkg::VAR_W +: eas_pkg::VAR_W],
                cmp_preset_in[c*eas_pkg::VAR_W +: eas_pkg::VAR_W],
                cmp_op_in[c*2 +: 2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand vectors; rules see sequence events in place of other rules,
    // which keeps rule outputs free of combinational loops
    always_comb
    begin
        event_vec = '0;
        event_vec[eas_pkg::OP_TRUE] = 1'b1;
        event_vec[eas_pkg::OP_STATUS_BASE +: eas_pkg::STATUS_W] = status_in;
        event_vec[eas_pkg::OP_DIN_BASE +: eas_pkg::DIN_W]       = digital_in;
        event_vec[eas_pkg::OP_TIMER_BASE +: eas_pkg::TIMER_N]   = timer_in;
        event_vec[eas_pkg::OP_CMP_BASE +: eas_pkg::CMP_N]       = cmp_result;
        event_vec[eas_pkg::OP_RULE_BASE +: eas_pkg::RULE_N]     = rule_result;
        rule_vec = event_vec;
        rule_vec[eas_pkg::OP_RULE_BASE +: eas_pkg::RULE_N] = '0;
        rule_vec[eas_pkg::OP_RULE_BASE + eas_pkg::EV_FIRED_SLOT] =
            event_true_reg;
        rule_vec[eas_pkg::OP_RULE_BASE + eas_pkg::EV_RUNNING_SLOT] =
            (state_reg == EAS_RUN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Logic rules
    for (genvar g = 0; g < eas_pkg::RULE_N; g++)
    begin : g_rule
        eas_logic_rule u_rule (
            .operand_vec_in (rule_vec),
            .select_in      (rule_operand_select_in[
                                g*eas_pkg::RULE_IN_N*eas_pkg::SEL_W +:
                                eas_pkg::RULE_IN_N*eas_pkg::SEL_W]),
            .invert_in      (rule_operand_invert_in[
                                g*eas_pkg::RULE_IN_N +: eas_pkg::RULE_IN_N]),
            .enable_in      (rule_operand_enable_in[
                                g*eas_pkg::RULE_IN_N +: eas_pkg::RULE_IN_N]),
            .operator_in    (rule_operator_in[
                                g*(eas_pkg::RULE_IN_N-1) +:
                                (eas_pkg::RULE_IN_N-1)]),
            .result_out     (rule_result[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Event selection for the single current index
    always_comb
    begin
        last_index    = clamp_pairs(num_pairs_in) - eas_pkg::IDX_ONE;
        cur_event_sel = sequencer_event_select_in[
                            int'(seq_index_reg)*eas_pkg::SEL_W +:
                            eas_pkg::SEL_W];
        cur_event_true = eas_pkg::pick_bit(event_vec, cur_event_sel);
        scan_eval = scan_strobe_in && (state_reg == EAS_RUN)
                    && !stop_in;
        fire = scan_eval && cur_event_true;
    end

    // Stop beats start when both arrive together
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            EAS_IDLE:
            begin
                if (start_in && !stop_in)
                begin
                    state_next = EAS_RUN;
                end
            end
            EAS_RUN:
            begin
                if (stop_in)
                begin
                    state_next = EAS_IDLE;
                end
            end
            default:
            begin
                state_next = EAS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        seq_index_next = seq_index_reg;
        if (stop_in || state_reg != EAS_RUN)
        begin
            seq_index_next = eas_pkg::IDX_ZERO;
        end
        else if (fire)
        begin
            if (seq_index_reg >= last_index)
            begin
                seq_index_next = eas_pkg::IDX_ZERO;
            end
            else
            begin
                seq_index_next = seq_index_reg + eas_pkg::IDX_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State and index
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg     <= EAS_IDLE;
            seq_index_reg <= eas_pkg::IDX_ZERO;
        end
        else
        begin
            state_reg     <= state_next;
            seq_index_reg <= seq_index_next;
        end
    end

    // Action output: one-cycle pulse, code and index held until next fire
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            action_valid_reg <= 1'b0;
            action_code_reg  <= eas_pkg::ACT_NONE;
            action_index_reg <= eas_pkg::IDX_ZERO;
        end
        else
        begin
            action_valid_reg <= fire;
            if (fire)
            begin
                action_code_reg  <= sequencer_action_select_in[
                                        int'(seq_index_reg)*eas_pkg::ACT_W +:
                                        eas_pkg::ACT_W];
                action_index_reg <= seq_index_reg;
            end
        end
    end

    // Observed results: event result captured at each evaluation, comparators and rules every cycle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            event_true_reg <= 1'b0;
        end
        else if (stop_in || state_reg != EAS_RUN)
        begin
            event_true_reg <= 1'b0;
        end
        else if (scan_eval)
        begin
            event_true_reg <= cur_event_true;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            comparator_reg <= '0;
            rule_reg       <= '0;
        end
        else
        begin
            comparator_reg <= cmp_result;
            rule_reg       <= rule_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign running_out      = (state_reg == EAS_RUN);
    assign seq_index_out    = seq_index_reg;
    assign action_valid_out = action_valid_reg;
    assign action_code_out  = action_code_reg;
    assign action_index_out = action_index_reg;
    assign event_true_out   = event_true_reg;
    assign comparator_out   = comparator_reg;
    assign rule_out         = rule_reg;

endmodule : eas_sequencer

// >>> sim/eas_sequencer_chk.sv
// Port-level checker for the event/action sequencer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module eas_sequencer_chk (
    input wire logic         clk_in,
    input wire logic         rst_n_in,
    input wire logic         scan_strobe_in,
    input wire logic         start_in,
    input wire logic         stop_in,
    input wire logic [4:0]   num_pairs_in,
    input wire logic [99:0]  sequencer_action_select_in,
    input wire logic         running_out,
    input wire logic [4:0]   seq_index_out,
    input wire logic         action_valid_out,
    input wire logic [4:0]   action_code_out,
    input wire logic [4:0]   action_index_out,
    input wire logic         event_true_out
);
    logic [4:0] eff_pairs;
    logic [4:0] cur_code;
    logic       fire_req;
    // Zero pairs reads as one, above twenty as twenty
    assign eff_pairs = (num_pairs_in == 5'h00) ? 5'h01 :
        (num_pairs_in > 5'h14) ? 5'h14 : num_pairs_in;
    assign cur_code = sequencer_action_select_in[5*seq_index_out +: 5];
    assign fire_req = running_out && scan_strobe_in && !stop_in;
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    fire_cause_a: assert property (
        action_valid_out |-> $past(fire_req))
        else $error("action without a taken strobe");
    fire_match_a: assert property (
        fire_req |=> action_valid_out == event_true_out)
        else $error("action does not follow event result");
    hold_false_a: assert property (
        fire_req ##1 !event_true_out |-> $stable(seq_index_out))
        else $error("index moved on a false event");
    no_strobe_a: assert property (
        running_out && !scan_strobe_in && !stop_in |=>
        $stable(seq_index_out) && !action_valid_out)
        else $error("index or action changed without strobe");
    advance_wrap_a: assert property (
        action_valid_out |-> seq_index_out ==
        (($past(seq_index_out) + 5'h01 >= $past(eff_pairs)) ?
        5'h00 : $past(seq_index_out) + 5'h01))
        else $error("wrong next index after action");
    pair_match_a: assert property (
        action_valid_out |-> action_index_out == $past(seq_index_out)
        && action_code_out == $past(cur_code))
        else $error("action not paired with its event");
    stop_clear_a: assert property (
        stop_in |=> !running_out && seq_index_out == 5'h00
        && !action_valid_out)
        else $error("stop did not clear sequencer");
    idle_quiet_a: assert property (
        !running_out |-> !action_valid_out && seq_index_out == 5'h00)
        else $error("idle sequencer not quiet");
    start_run_a: assert property (
        !running_out && start_in && !stop_in |=> running_out)
        else $error("start did not run sequencer");
endmodule : eas_sequencer_chk

bind eas_sequencer eas_sequencer_chk u_chk (
    .clk_in, .rst_n_in, .scan_strobe_in, .start_in, .stop_in,
    .num_pairs_in, .sequencer_action_select_in, .running_out,
    .seq_index_out, .action_valid_out, .action_code_out,
    .action_index_out, .event_true_out
);

// >>> sim/eas_core_model.sv
// Behavioural drive core: supplies status and variables, counts actions.
// Assumes the bench calls its tasks away from the rising clock edge.
`timescale 1ns/1ps
module eas_core_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        action_valid_in,
    output logic [15:0]      status_out,
    output logic [63:0]      variable_out,
    output logic [7:0]       act_count_out
);
    initial status_out = 16'h0000;
    initial variable_out = 64'h0000;
    // Counts pulses so a double fire would show
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            act_count_out <= 8'h00;
        else if (action_valid_in)
            act_count_out <= act_count_out + 8'h01;
    end
    task set_status(input logic [15:0] s);
        status_out = s;
    endtask : set_status
    task set_var(input logic [63:0] v);
        variable_out = v;
    endtask : set_var
endmodule : eas_core_model

// >>> sim/tb.sv
// Self-checking bench for the event/action sequencer.
// Assumes inputs change at the falling edge, outputs one cycle late.
`timescale 1ns/1ps
module tb;
    logic clk_in, rst_n_in, strobe, start, stop;
    logic [4:0] npairs;
    logic [119:0] ev_sel;
    logic [99:0] act_sel;
    logic [7:0] din, cvs, cop, ropr;
    logic [3:0] tmr, cmp_o, rule_o;
    logic [63:0] cpre, vars;
    logic [71:0] rsel;
    logic [11:0] rinv, ren;
    logic [15:0] status;
    logic [4:0] seq_idx, act_c, act_i;
    logic running, act_v, ev_t, e;
    logic [7:0] acts;
    int n_fail, n_compared;
    eas_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .action_valid_in(act_v), .status_out(status),
        .variable_out(vars), .act_count_out(acts));
    eas_sequencer dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .scan_strobe_in(strobe), .start_in(start), .stop_in(stop),
        .num_pairs_in(npairs), .sequencer_event_select_in(ev_sel),
        .sequencer_action_select_in(act_sel), .status_in(status),
        .digital_in(din), .timer_in(tmr), .variable_in(vars),
        .cmp_var_select_in(cvs), .cmp_op_in(cop), .cmp_preset_in(cpre),
        .rule_operand_select_in(rsel), .rule_operand_invert_in(rinv),
        .rule_operand_enable_in(ren), .rule_operator_in(ropr),
        .running_out(running), .seq_index_out(seq_idx),
        .action_valid_out(act_v), .action_code_out(act_c),
        .action_index_out(act_i), .event_true_out(ev_t),
        .comparator_out(cmp_o), .rule_out(rule_o));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_compared++;
        if (g !== x)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // One strobe, judged at the next falling edge, then one idle cycle
    // so back-to-back calls never drive the strobe twice in one step
    task automatic scan(input logic f, input logic [4:0] ni,
                        input logic [4:0] code);
        logic [4:0] idx;
        idx = seq_idx;
        strobe = 1'b1;
        @(negedge clk_in);
        strobe = 1'b0;
        chk("action_valid", f, act_v);
        chk("event_true", f, ev_t);
        chk("seq_index", ni, seq_idx);
        if (f)
        begin
            chk("action_code", code, act_c);
            chk("action_index", idx, act_i);
        end
        @(negedge clk_in);
    endtask : scan
    task automatic restart();
        stop = 1'b1;
        @(negedge clk_in);
        stop = 1'b0;
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        chk("running", 1, running);
    endtask : restart
    ////////////////////////////////////////////////////////////////////////
    task automatic t_walk();
        npairs = 5'h03;
        ev_sel[17:0] = {6'h01, 6'h02, 6'h01};
        act_sel[14:0] = {5'h0c, 5'h0b, 5'h0a};
        restart();
        repeat (2) @(negedge clk_in);
        chk("idle_index", 0, seq_idx);
        scan(1, 5'h01, 5'h0a);
        scan(0, 5'h01, 5'h00);
        core.set_status(16'h0001);
        scan(1, 5'h02, 5'h0b);
        scan(1, 5'h00, 5'h0c);
        chk("actions", 3, acts);
    endtask : t_walk
    task automatic t_stop();
        scan(1, 5'h01, 5'h0a);
        stop = 1'b1;
        strobe = 1'b1;
        @(negedge clk_in);
        stop = 1'b0;
        chk("stopped", 0, {running, seq_idx, act_v});
        scan(0, 5'h00, 5'h00);
    endtask : t_stop
    task automatic t_pairs();
        ev_sel = {20{6'h01}};
        for (int i = 0; i < 20; i++)
            act_sel[5*i +: 5] = 5'(i);
        npairs = 5'h14;
        restart();
        for (int i = 0; i < 20; i++)
            scan(1, 5'((i + 1) % 20), 5'(i));
        npairs = 5'h00;
        scan(1, 5'h00, 5'h00);
    endtask : t_pairs
    task automatic t_cmp();
        logic [15:0] p;
        core.set_var(64'h0100);
        cvs = 8'h00;
        for (int o = 0; o < 4; o++)
            for (int k = 0; k < 3; k++)
            begin
                p = 16'h00ff + 16'(k);
                cop[1:0] = 2'(o);
                cpre[15:0] = p;
                @(negedge clk_in);
                e = (o == 0) ? 16'h0100 < p : (o == 1) ? 16'h0100 == p :
                    (o == 2) ? 16'h0100 > p : 16'h0100 != p;
                chk("comparator", e, cmp_o[0]);
            end
        npairs = 5'h01;
        ev_sel[5:0] = 6'h1e;
        cop[1:0] = 2'h1;
        cpre[15:0] = 16'h0100;
        scan(1, 5'h00, 5'h00);
    endtask : t_cmp
    task automatic t_rule();
        logic [3:0] b;
        rsel[17:0] = {6'h1a, 6'h12, 6'h03};
        ren = 12'h007;
        rinv = 12'h002;
        for (int i = 0; i < 16; i++)
        begin
            b = 4'(i);
            core.set_status({14'h0000, b[0], 1'b0});
            din[0] = b[1];
            tmr[0] = b[2];
            ropr[1:0] = {~b[3], b[3]};
            @(negedge clk_in);
            e = b[3] ? (b[0] | ~b[1]) : (b[0] & ~b[1]);
            e = b[3] ? (e & b[2]) : (e | b[2]);
            chk("rule", e, rule_o[0]);
        end
        ev_sel[5:0] = 6'h22;
        scan(1, 5'h00, 5'h00);
        rsel[5:0] = 6'h23;
        ren = 12'h001;
        rinv = 12'h000;
        @(negedge clk_in);
        chk("rule_running", 1, rule_o[0]);
        rsel[5:0] = 6'h22;
        @(negedge clk_in);
        chk("rule_event", 1, rule_o[0]);
    endtask : t_rule
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        {rst_n_in, strobe, start, stop} = 4'h0;
        {npairs, ev_sel, act_sel, din, cvs, cop, ropr, tmr} = '0;
        {cpre, rsel, rinv, ren} = '0;
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_walk();
        t_stop();
        t_pairs();
        t_cmp();
        t_rule();
        report_and_stop();
    end
endmodule : tb
